// File: spimsp_top.sv
// serial peripheral port, master or slave, behind an avalon-mm register slave
//
// Contract
// R1: four pins: mosi, miso, select, clock
// R2: master drives mosi, slave receives it
// R3: slave drives miso, master samples it
// R4: master may drive select; slave reads it
// R5: master makes clock; slave takes it in
// R6: 8 or 16 bit transfers
// R7: reserved bits read zero, ignore writes
// R8: irq_enable gates done and fault requests
// R9: system_enable off idles, clears status
// R10: tx_empty_irq_enable gates empty request
// R11: master_select picks role; change idles port
// R12: clock_polarity sets idle clock level
// R13: far end uses same clock polarity
// R14: clock_phase picks odd or even sampling edges
// R15: master: polarity or phase change aborts
// R16: wait without stop_in_wait: run normally
// R17: wait with stop_in_wait: master pauses, resumes
// R18: stop mode: master pauses, resumes later
// R19: slave keeps shifting in low power
// R20: select output, fault input or unused
// R21: width bit joins data bytes; change aborts; code aborts on it in master mode only
// R22: lsb_first picks shift order only; code also aborts on its change in master mode
// R23: bidir mode uses one gated data pin
// R24: separate receive and transmit buffers
// R25: clock rate from prescaler and divider
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "spimsp_regs.svh"

module spimsp_top
    import spimsp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave, byte address
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // processor power state
    input wire logic wait_mode,
    input wire logic stop_mode,
    // link pins
    input wire spimsp_pins_t pin_in,
    output spimsp_pins_t pin_out,
    output spimsp_pins_t pin_oe,
    // interrupt request
    output logic irq
);

    // bit position within the word for shift index idx
    function automatic logic [3:0] bitpos(input logic [3:0] idx, input logic lsbf,
                                          input logic w16);
        logic [3:0] top;
        top = w16 ? 4'hf : 4'h7;
        bitpos = lsbf ? idx : 4'(top - idx);
    endfunction

    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [7:0] baud_r;
    logic done_r;
    logic txe_r;
    logic mode_fault_r;
    logic [15:0] tx_buf_r;
    logic [15:0] rx_buf_r;
    logic [15:0] tx_sh_r;
    logic [15:0] rx_sh_r;
    logic [15:0] rx_sh_nxt;
    spimsp_state_t state_r;
    logic [5:0] edge_cnt_r;
    logic [10:0] half_cnt_r;
    logic sck_lvl_r;
    logic ack_r;
    spimsp_pins_t sync1_r;
    spimsp_pins_t sync2_r;
    logic sck_d_r;
    logic hold_sel_r;

    // decoded control bits
    logic sys_en, master, clock_polarity, clock_phase, lsbf, ss_output_enable, w16, mode_fault_en, bidir, bidir_oe;
    assign sys_en = ctrl1_r[`SPIMSP_C1_SYS_EN];
    assign master = ctrl1_r[`SPIMSP_C1_MASTER]; // [R11]
    assign clock_polarity = ctrl1_r[`SPIMSP_C1_CLOCK_POLARITY];
    assign clock_phase = ctrl1_r[`SPIMSP_C1_CLOCK_PHASE];
    assign lsbf = ctrl1_r[`SPIMSP_C1_LSBF];
    assign ss_output_enable = ctrl1_r[`SPIMSP_C1_SS_OUTPUT_ENABLE];
    assign w16 = ctrl2_r[`SPIMSP_C2_WIDTH16];
    assign mode_fault_en = ctrl2_r[`SPIMSP_C2_MODE_FAULT_EN];
    assign bidir = ctrl2_r[`SPIMSP_C2_BIDIR];
    assign bidir_oe = ctrl2_r[`SPIMSP_C2_BIDIR_OE];

    // bus access: one wait cycle, then completion
    logic acc, wr_en, rd_en;
    logic [2:0] idx;
    assign acc = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack_r;
    assign idx = avs_address[4:2];
    assign wr_en = avs_write & ack_r & avs_byteenable[0];
    assign rd_en = avs_read & ack_r;

    logic wr_c1, wr_c2, wr_br, wr_dh, wr_dl, rd_dl;
    assign wr_c1 = wr_en & (idx == `SPIMSP_IDX_CTRL1);
    assign wr_c2 = wr_en & (idx == `SPIMSP_IDX_CTRL2);
    assign wr_br = wr_en & (idx == `SPIMSP_IDX_BAUD);
    assign wr_dh = wr_en & (idx == `SPIMSP_IDX_DATAH);
    assign wr_dl = wr_en & (idx == `SPIMSP_IDX_DATAL);
    assign rd_dl = rd_en & (idx == `SPIMSP_IDX_DATAL);

    logic [7:0] c1_new, c2_new;
    assign c1_new = avs_writedata[7:0] & `SPIMSP_C1_MASK; // [R7]
    assign c2_new = avs_writedata[7:0] & `SPIMSP_C2_MASK; // [R7]

    // writes that force the port idle
    logic abort_wr;
    always_comb begin
        abort_wr = 1'b0;
        if (wr_c1) begin
            if (c1_new[`SPIMSP_C1_MASTER] != master) begin
                abort_wr = 1'b1; // [R11]
            end
            if (~c1_new[`SPIMSP_C1_SYS_EN]) begin
                abort_wr = 1'b1; // [R9]
            end
            if (master && c1_new[3:0] != ctrl1_r[3:0]) begin
                abort_wr = 1'b1; // [R15] [R22]
            end
        end
        if (wr_c2 && master) begin
            if (c2_new[`SPIMSP_C2_WIDTH16] != w16 || c2_new[`SPIMSP_C2_MODE_FAULT_EN] != mode_fault_en
                || c2_new[`SPIMSP_C2_BIDIR] != bidir) begin
                abort_wr = 1'b1; // [R21]
            end
            if (bidir && c2_new[`SPIMSP_C2_BIDIR_OE] != bidir_oe) begin
                abort_wr = 1'b1; // [R23]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc & ~ack_r;
        end
    end

    // read data settles one cycle before completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (acc & ~ack_r) begin
            case (idx)
                `SPIMSP_IDX_CTRL1: avs_readdata <= {24'h00_0000, ctrl1_r};
                `SPIMSP_IDX_CTRL2: avs_readdata <= {24'h00_0000, ctrl2_r};
                `SPIMSP_IDX_BAUD: avs_readdata <= {24'h00_0000, baud_r};
                `SPIMSP_IDX_STAT: avs_readdata <= {24'h00_0000, done_r, 1'b0, txe_r, mode_fault_r,
                                                   4'h0}; // [R7]
                `SPIMSP_IDX_DATAH: avs_readdata <= {24'h00_0000, rx_buf_r[15:8]}; // [R24]
                `SPIMSP_IDX_DATAL: avs_readdata <= {24'h00_0000, rx_buf_r[7:0]}; // [R24]
                default: avs_readdata <= 32'h0000_0000; // [R7]
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl1_r <= `SPIMSP_C1_RST;
            ctrl2_r <= `SPIMSP_C2_RST;
            baud_r <= `SPIMSP_BR_RST;
        end else begin
            if (wr_c1) begin
                ctrl1_r <= c1_new;
            end
            if (wr_c2) begin
                ctrl2_r <= c2_new;
            end
            if (wr_br) begin
                baud_r <= avs_writedata[7:0] & `SPIMSP_BR_MASK;
            end
        end
    end

    // transmit holding buffer; high byte only used at 16 bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_buf_r <= 16'h0000;
        end else begin
            if (wr_dh) begin
                tx_buf_r[15:8] <= avs_writedata[7:0]; // [R24]
            end
            if (wr_dl) begin
                tx_buf_r[7:0] <= avs_writedata[7:0]; // [R24]
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            sync2_r <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            sck_d_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sck_d_r <= sync2_r.sck;
        end
    end

    // master pauses in stop, or in wait with stop_in_wait
    logic pause;
    assign pause = stop_mode | (wait_mode & ctrl2_r[`SPIMSP_C2_STOP_WAIT]); // [R16] [R17] [R18]

    logic ss_fault_in, ss_drive;
    assign ss_fault_in = master & mode_fault_en & ~ss_output_enable; // [R20]
    assign ss_drive = master & mode_fault_en & ss_output_enable; // [R20] [R4]

    logic fault;
    assign fault = sys_en & ss_fault_in & ~sync2_r.ss_n;

    logic slave_act;
    assign slave_act = sys_en & ~master & ~sync2_r.ss_n; // [R4]

    // baud: half period = (prescale + 1) << divider bus cycles
    logic [10:0] half_period;
    assign half_period = 11'({7'h00, 1'b0, baud_r[6:4]} + 11'h001) << baud_r[2:0]; // [R25]

    logic half_hit;
    assign half_hit = (half_cnt_r == 11'(half_period - 11'h001));

    logic kill;
    assign kill = abort_wr | fault | ~sys_en;

    logic run_master;
    assign run_master = sys_en & master & (state_r == SPIMSP_SHIFT) & ~pause; // [R17] [R18]

    logic edge_ev;
    assign edge_ev = master ? (run_master & half_hit)
                            : (slave_act & (state_r == SPIMSP_SHIFT)
                               & (sync2_r.sck ^ sck_d_r)); // [R5] [R19]

    logic start;
    assign start = (state_r == SPIMSP_IDLE) & ~wr_dl & ~kill & ~hold_sel_r
                   & (master ? (~txe_r & ~pause) : slave_act);

    // receive input pin by role and pin mode
    logic in_bit;
    assign in_bit = master ? (bidir ? sync2_r.mosi : sync2_r.miso)
                           : (bidir ? sync2_r.miso : sync2_r.mosi); // [R2] [R3] [R23]

    logic sample_now;
    assign sample_now = edge_ev & (clock_phase ? edge_cnt_r[0] : ~edge_cnt_r[0]); // [R14]

    logic [5:0] n_edges;
    assign n_edges = w16 ? `SPIMSP_EDGES16 : `SPIMSP_EDGES8; // [R6] [R21]

    logic last_edge;
    assign last_edge = edge_ev & (6'(edge_cnt_r + 6'h01) == n_edges);

    always_comb begin
        rx_sh_nxt = rx_sh_r;
        if (sample_now) begin
            rx_sh_nxt[bitpos(edge_cnt_r[4:1], lsbf, w16)] = in_bit; // [R22]
        end
    end

    // output bit index: phase 1 presents each bit one edge later
    logic [3:0] out_idx;
    assign out_idx = (clock_phase && edge_cnt_r != 6'h00) ? 4'(6'(edge_cnt_r - 6'h01) >> 1)
                                                   : edge_cnt_r[4:1]; // [R14]

    logic out_bit;
    assign out_bit = tx_sh_r[bitpos(out_idx, lsbf, w16)]; // [R22]

    // shift engine, shared by both roles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= SPIMSP_IDLE;
            edge_cnt_r <= 6'h00;
            tx_sh_r <= 16'h0000;
            rx_sh_r <= 16'h0000;
            rx_buf_r <= 16'h0000;
        end else if (kill || (!master && sync2_r.ss_n)) begin
            // slave deselect mid-word drops the partial word
            state_r <= SPIMSP_IDLE; // [R9] [R11] [R15]
            edge_cnt_r <= 6'h00;
        end else if (start) begin
            state_r <= SPIMSP_SHIFT;
            edge_cnt_r <= 6'h00;
            tx_sh_r <= tx_buf_r; // [R24]
        end else if (edge_ev) begin
            rx_sh_r <= rx_sh_nxt;
            edge_cnt_r <= 6'(edge_cnt_r + 6'h01);
            if (last_edge) begin
                state_r <= SPIMSP_IDLE;
                edge_cnt_r <= 6'h00;
                rx_buf_r <= w16 ? rx_sh_nxt : {8'h00, rx_sh_nxt[7:0]}; // [R6] [R24]
            end
        end
    end

    // select and data hold one cycle past the last edge: a far end sampling
    // on that edge must not see the select rise or the data move with it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_sel_r <= 1'b0;
        end else begin
            hold_sel_r <= last_edge & ~kill;
        end
    end

    // master clock: half-period counter frozen while paused
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_cnt_r <= 11'h000;
            sck_lvl_r <= 1'b0;
        end else if (kill || state_r == SPIMSP_IDLE) begin
            half_cnt_r <= 11'h000;
            sck_lvl_r <= 1'b0;
        end else if (run_master) begin
            if (half_hit) begin
                half_cnt_r <= 11'h000;
                sck_lvl_r <= ~sck_lvl_r; // [R25]
            end else begin
                half_cnt_r <= 11'(half_cnt_r + 11'h001);
            end
        end
    end

    // status flags: hardware set wins over software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
            txe_r <= 1'b1;
            mode_fault_r <= 1'b0;
        end else if (~sys_en) begin
            done_r <= 1'b0; // [R9]
            txe_r <= 1'b1; // [R9]
            mode_fault_r <= 1'b0; // [R9]
        end else begin
            if (last_edge && !kill) begin
                done_r <= 1'b1;
            end else if (rd_dl) begin
                done_r <= 1'b0;
            end
            if (start) begin
                txe_r <= 1'b1;
            end else if (wr_dl) begin
                txe_r <= 1'b0;
            end
            if (fault) begin
                mode_fault_r <= 1'b1; // [R20]
            end else if (wr_c1) begin
                mode_fault_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (ctrl1_r[`SPIMSP_C1_IRQ_EN] & (done_r | mode_fault_r)) // [R8]
                   | (ctrl1_r[`SPIMSP_C1_TXE_IRQ_EN] & txe_r); // [R10]
        end
    end

    // registered pin drivers; all released while disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
            pin_oe <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b0};
        end else begin
            pin_out.sck <= clock_polarity ^ sck_lvl_r; // [R12]
            if (!hold_sel_r) begin
                pin_out.mosi <= out_bit; // [R2]
                pin_out.miso <= out_bit; // [R3]
            end
            pin_out.ss_n <= ~(state_r == SPIMSP_SHIFT || hold_sel_r); // [R4]
            pin_oe.sck <= sys_en & master; // [R5] [R1]
            pin_oe.mosi <= sys_en & master & (~bidir | bidir_oe); // [R2] [R23]
            pin_oe.miso <= slave_act & (~bidir | bidir_oe); // [R3] [R23]
            pin_oe.ss_n <= sys_en & ss_drive; // [R4] [R20]
        end
    end

endmodule

// File: spimsp_regs.svh
// register map, field positions, reset values and counts of the serial port
`ifndef SPIMSP_REGS_SVH
`define SPIMSP_REGS_SVH

// register indices; byte address is four times the index
`define SPIMSP_IDX_CTRL1 3'h0
`define SPIMSP_IDX_CTRL2 3'h1
`define SPIMSP_IDX_BAUD 3'h2
`define SPIMSP_IDX_STAT 3'h3
`define SPIMSP_IDX_DATAH 3'h4
`define SPIMSP_IDX_DATAL 3'h5

// control_one fields
`define SPIMSP_C1_IRQ_EN 7
`define SPIMSP_C1_SYS_EN 6
`define SPIMSP_C1_TXE_IRQ_EN 5
`define SPIMSP_C1_MASTER 4
`define SPIMSP_C1_CLOCK_POLARITY 3
`define SPIMSP_C1_CLOCK_PHASE 2
`define SPIMSP_C1_SS_OUTPUT_ENABLE 1
`define SPIMSP_C1_LSBF 0

// control_two fields
`define SPIMSP_C2_WIDTH16 6
`define SPIMSP_C2_MODE_FAULT_EN 4
`define SPIMSP_C2_BIDIR_OE 3
`define SPIMSP_C2_STOP_WAIT 1
`define SPIMSP_C2_BIDIR 0

// status_flags fields
`define SPIMSP_SR_DONE 7
`define SPIMSP_SR_TXE 5
`define SPIMSP_SR_MODE_FAULT 4

// writable masks, reserved bits stay zero
`define SPIMSP_C1_MASK 8'hff
`define SPIMSP_C2_MASK 8'h5b
`define SPIMSP_BR_MASK 8'h77

// reset values
`define SPIMSP_C1_RST 8'h00
`define SPIMSP_C2_RST 8'h00
`define SPIMSP_BR_RST 8'h00

// edges per transfer
`define SPIMSP_EDGES8 6'h10
`define SPIMSP_EDGES16 6'h20

`endif

// File: spimsp_pkg.sv
// types shared by the serial port design
package spimsp_pkg;

    // the four link pins, one bit each
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spimsp_pins_t;

    typedef enum logic [0:0] {
        SPIMSP_IDLE = 1'b0,
        SPIMSP_SHIFT = 1'b1
    } spimsp_state_t;

endpackage

// File: spimsp_assertions.sv
// concurrent checks on the serial port's bus and pins
`timescale 1ns/1ps
module spimsp_chk
    import spimsp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_write,
    input wire logic avs_read,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // link and request
    input wire spimsp_pins_t pin_out,
    input wire spimsp_pins_t pin_oe,
    input wire logic irq
);
    logic [7:0] c1_r;
    logic [7:0] c2_r;
    logic [5:0] n_r;
    logic sck_r;
    logic wr;
    assign wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
    // shadow of the control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c1_r <= 8'h00;
            c2_r <= 8'h00;
        end else if (wr && avs_address[4:2] == 3'h0) begin
            c1_r <= avs_writedata[7:0];
        end else if (wr && avs_address[4:2] == 3'h1) begin
            c2_r <= avs_writedata[7:0] & 8'h5b;
        end
    end
    // clock edges seen while the select is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            n_r <= 6'h00;
            sck_r <= 1'b0;
        end else begin
            sck_r <= pin_out.sck;
            if (pin_out.ss_n) begin
                n_r <= 6'h00;
            end else if (pin_out.sck != sck_r) begin
                n_r <= n_r + 6'h01;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_upper_zero: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper");
    a_rsvd_zero: assert property (
        avs_read && !avs_waitrequest && avs_address[4:3] == 2'b11 |-> avs_readdata == 32'h0)
        else $error("reserved");
    a_irq_gated: assert property (
        !c1_r[7] && !c1_r[5] && $stable(c1_r) |=> !irq) else $error("irq");
    a_idle_pol: assert property (
        c1_r[6] && c1_r[4] && pin_oe.ss_n && pin_out.ss_n && $past(pin_out.ss_n)
        && c1_r == $past(c1_r, 2) |-> pin_out.sck == c1_r[3]) else $error("idle level");
    a_sck_drive: assert property (
        c1_r[6] && c1_r == $past(c1_r, 2) |-> pin_oe.sck == c1_r[4]) else $error("sck drive");
    a_ss_drive: assert property (
        c1_r[6] && c1_r == $past(c1_r, 2) && c2_r == $past(c2_r, 2)
        |-> pin_oe.ss_n == (c1_r[4] && c2_r[4] && c1_r[1])) else $error("select drive");
    a_data_dir: assert property (
        c1_r[6] && !c2_r[0] && c1_r == $past(c1_r, 2)
        |-> !(c1_r[4] ? pin_oe.miso : pin_oe.mosi)) else $error("direction");
    a_edge_count: assert property (
        $rose(pin_out.ss_n) && pin_oe.ss_n |-> n_r + 6'(pin_out.sck != sck_r)
        == (c2_r[6] ? 6'h20 : 6'h10)) else $error("edge count");
    c_xfer: cover property ($rose(pin_out.ss_n));
    c_irq: cover property ($rose(irq));
    c_rsvd: cover property (avs_read && !avs_waitrequest && avs_address[4:3] == 2'b11);
endmodule
bind spimsp_top spimsp_chk spimsp_chk_i (.clk, .rst, .avs_address, .avs_write, .avs_read,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe, .irq);

// File: spimsp_peer.sv
// far-end slave model answering the port in master mode
`timescale 1ns/1ps
module spimsp_peer (
    // link pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // word format, set to match the port
    input wire logic clock_phase,
    input wire logic w16,
    input wire logic lsbf,
    // words exchanged
    input wire logic [15:0] tx,
    output logic [15:0] rx
);
    int e;
    int k;
    function automatic logic pick(int i);
        return tx[lsbf ? i : (w16 ? 15 : 7) - i];
    endfunction
    initial miso = 1'b0;
    // released line shows the inverse, never a stale bit
    always @(posedge ss_n) miso = ~miso;
    always @(negedge ss_n) begin
        e = 0;
        k = 0;
        rx = 16'h0;
        if (!clock_phase) begin
            miso = pick(0);
            k = 1;
        end
    end
    // edges counted from the idle level both ends agree on
    always @(sck) begin
        if (ss_n === 1'b0) begin
            e++;
            if ((e % 2 == 1) != clock_phase) begin
                rx = lsbf ? rx | (16'(mosi) << ((e - 1) / 2)) : {rx[14:0], mosi};
            end else if (k < (w16 ? 16 : 8)) begin
                miso = pick(k);
                k++;
            end
        end
    end
endmodule

// File: tb.sv
// bench: register map, master transfers in all four clock modes, both widths and both bit orders, irq, low power
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin miscompares++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module tb
    import spimsp_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    spimsp_pins_t pin_in, pin_out, pin_oe;
    logic irq, peer_miso;
    logic clock_phase = 1'b0;
    logic w16 = 1'b0;
    logic lsbf = 1'b0;
    logic [15:0] ptx = 16'h0;
    logic [15:0] prx, dtx;
    logic [7:0] q;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int check_count = 0;
    always #4 clk = ~clk;
    // undriven pins: clock pulled low, mosi and select pulled high
    assign pin_in = {pin_out.sck & pin_oe.sck, pin_out.mosi | ~pin_oe.mosi, peer_miso,
        pin_out.ss_n | ~pin_oe.ss_n};
    spimsp_top spimsp_top_i (.clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest, .wait_mode,
        .stop_mode, .pin_in, .pin_out, .pin_oe, .irq);
    spimsp_peer spimsp_peer_i (.sck(pin_in.sck), .mosi(pin_in.mosi), .ss_n(pin_in.ss_n),
        .miso(peer_miso), .clock_phase, .w16, .lsbf, .tx(ptx), .rx(prx));
    task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) miscompares++;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic [7:0] c1;
        logic s0;
        int k;
        void'($urandom(87));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 3'(i), 8'h00);
            `CHK(q, (i == 3) ? 8'h20 : 8'h00)
        end
        for (int i = 0; i < 5; i++) begin
            k = (i < 3) ? i + 1 : i + 3;
            bus(1'b1, 3'(k), 8'hff);
            bus(1'b0, 3'(k), 8'h00);
            `CHK(q, 40'h5b77200000 >> (8 * (4 - i)) & 8'hff)
        end
        bus(1'b1, 3'h2, 8'h30); // half period 4 clocks, a 64 ns link clock
        for (int m = 0; m < 6; m++) begin
            clock_phase <= m[1];
            w16 <= m > 3;
            lsbf <= m == 3 || m == 5;
            ptx <= 16'($urandom);
            dtx = 16'($urandom);
            c1 = {4'h5, m[0], m[1], 1'b1, m == 3 || m == 5};
            bus(1'b1, 3'h1, {1'b0, m > 3, 4'h4, m == 2, 1'b0});
            bus(1'b1, 3'h0, c1);
            repeat (3) @(posedge clk);
            `CHK(pin_out.sck, c1[3])
            if (m > 3) bus(1'b1, 3'h4, dtx[15:8]);
            bus(1'b1, 3'h5, dtx[7:0]);
            exp_q.push_back(m > 3 ? ptx : {8'h00, ptx[7:0]});
            if (m < 3) begin
                repeat (24) @(posedge clk);
                wait_mode <= m != 1;
                stop_mode <= m == 1;
                repeat (3) @(negedge clk);
                s0 = pin_out.sck;
                k = 1;
                repeat (40) begin
                    @(negedge clk);
                    if (pin_out.sck !== s0) k = 0;
                end
                `CHK(k, (m > 0) ? 1 : 0)
                @(posedge clk);
                wait_mode <= 1'b0;
                stop_mode <= 1'b0;
            end
            k = 0;
            do begin
                bus(1'b0, 3'h3, 8'h00);
                k++;
            end while (q[7] !== 1'b1 && k < 200);
            `CHK(q[7], 1'b1)
            `CHK(prx, m > 3 ? dtx : {8'h00, dtx[7:0]})
            if (m == 5) begin
                bus(1'b1, 3'h0, c1 | 8'h80);
                repeat (2) @(posedge clk);
                `CHK(irq, 1'b1)
                bus(1'b1, 3'h0, c1);
                repeat (2) @(posedge clk);
                `CHK(irq, 1'b0)
                bus(1'b1, 3'h0, c1 | 8'h20);
                repeat (2) @(posedge clk);
                `CHK(irq, 1'b1)
                bus(1'b1, 3'h0, 8'h00);
                bus(1'b0, 3'h3, 8'h00);
                `CHK(q, 8'h20)
            end
            bus(1'b0, 3'h4, 8'h00);
            dtx[15:8] = q;
            bus(1'b0, 3'h5, 8'h00);
            `CHK({dtx[15:8], q}, exp_q.pop_front())
        end
        report_and_stop();
    end
endmodule
